// >>> fbpc_pkg.sv
// Constants and types for the host-side flash bus pin controller.
// Assumes a single 40 MHz clock and an asynchronous parallel flash outside.
package fbpc_pkg;
   // =========================================================
   // Widths
   localparam int ADDR_W = 22;               // Widest part, A0..A21
   localparam int DATA_W = 16;               // Word-wide data bus
   // =========================================================
   // Timing, in ns and in 25 ns cycles
   localparam int CLK_NS      = 25;          // 40 MHz period
   localparam int SETUP_NS    = 50;          // Address/data setup
   localparam int PULSE_NS    = 75;          // Strobe low time
   localparam int ACCESS_NS   = 100;         // Read access time
   localparam int HOLD_NS     = 25;          // Recovery after strobe
   localparam int RST_LOW_NS  = 150;         // Reset pin low time
   localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] PULSE_CYC  = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] ACCESS_CYC = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RST_CYC    = 4'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
   // =========================================================
   // Request kinds
   typedef enum logic [1:0] {
      FBPC_OP_READ  = 2'b00,                 // One read cycle
      FBPC_OP_WRITE = 2'b01,                 // One write cycle (command)
      FBPC_OP_PAIR  = 2'b10,                 // Two writes: command, data
      FBPC_OP_RESET = 2'b11                  // Pulse reset pin low
   } fbpc_op_t;
   // Bus sequencer states
   typedef enum logic [2:0] {
      FBPC_IDLE  = 3'b000,                   // Bus parked
      FBPC_SETUP = 3'b001,                   // Address/data settle
      FBPC_PULSE = 3'b010,                   // Strobe low
      FBPC_HOLD  = 3'b011,                   // Recovery, strobe high
      FBPC_RST   = 3'b100                    // Reset pin held low
   } fbpc_state_t;
endpackage

// >>> fbpc_sync.sv
// Two-flop synchroniser for the data pins read back from the flash.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/1ps
module fbpc_sync #(
   parameter int W = 16                      // Width
) (
   input  wire logic         clk,            // Clock
   input  wire logic         rst,            // Async reset, high
   input  wire logic [W-1:0] d,              // Async input
   output logic      [W-1:0] q               // Synchronised output
);
   logic [W-1:0] meta_r;                     // First stage, read by q only
   logic [W-1:0] meta_nxt;                   // Next first stage
   logic [W-1:0] q_nxt;                      // Next second stage

   // =========================================================
   // Next values
   always_comb begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= meta_nxt;
         q      <= q_nxt;
      end
   end
endmodule

// >>> fbpc_host.sv
// Host-side bus controller for an asynchronous parallel flash.
// Assumes requests from same-clock logic and flash pins outside the chip.
`timescale 1ns/1ps
module fbpc_host (
   input  wire logic                        clk,       // 40 MHz clock
   input  wire logic                        rst,       // Async reset, high
   input  wire logic                        req_valid, // Request strobe
   input  wire logic [1:0]                  req_op,    // Request kind
   input  wire logic [fbpc_pkg::ADDR_W-1:0] req_addr,  // Flash address
   input  wire logic [7:0]                  req_cmd,   // Command byte
   input  wire logic [fbpc_pkg::DATA_W-1:0] req_data,  // Program data
   input  wire logic                        wide_bus,  // 1: word-wide part
   input  wire logic                        protect_n, // Lock-down wanted
   output logic                             busy,      // Sequence active
   output logic                             rsp_valid, // Read data pulse
   output logic [fbpc_pkg::DATA_W-1:0]      rsp_data,  // Read data
   output logic [fbpc_pkg::ADDR_W-1:0]      flash_addr, // Address pins
   output logic [fbpc_pkg::DATA_W-1:0]      dq_drive,  // Data pin drive
   output logic                             dq_oe_n,   // Low: host drives
   input  wire logic [fbpc_pkg::DATA_W-1:0] dq_pin,    // Data pin level
   output logic                             chip_sel_n,      // Chip select
   output logic                             out_en_n,        // Output enable
   output logic                             write_n,         // Write strobe
   output logic                             reset_powerdown_n, // Reset pin
   output logic                             write_protect_n  // Protect pin
);
   // =========================================================
   // State
   fbpc_pkg::fbpc_state_t st_r, st_nxt;      // Sequencer state
   logic [1:0]  op_r, op_nxt;                // Latched request kind
   logic        second_r, second_nxt;        // Second write of a pair
   logic [3:0]  cnt_r, cnt_nxt;              // Phase counter
   logic [fbpc_pkg::DATA_W-1:0] dq_sync;     // Synchronised read data
   logic [fbpc_pkg::DATA_W-1:0] wdata_r, wdata_nxt; // Held program data
   logic        busy_nxt, rsp_valid_nxt;     // Output next values
   logic [fbpc_pkg::DATA_W-1:0] rsp_data_nxt;
   logic [fbpc_pkg::ADDR_W-1:0] addr_nxt;
   logic [fbpc_pkg::DATA_W-1:0] dq_nxt;
   logic        dq_oe_n_nxt, cs_n_nxt, oe_n_nxt, we_n_nxt, rp_n_nxt, wp_nxt;

   // Mask address to the part's width; top pin is NC on word-wide parts
   function automatic logic [fbpc_pkg::ADDR_W-1:0] mask_addr(
      input logic [fbpc_pkg::ADDR_W-1:0] a, input logic wide);
      mask_addr = wide ? {1'b0, a[fbpc_pkg::ADDR_W-2:0]} : a;
   endfunction

   // Byte parts have no upper data lines: drive zero, read zero
   function automatic logic [fbpc_pkg::DATA_W-1:0] fit_data(
      input logic [fbpc_pkg::DATA_W-1:0] d, input logic wide);
      fit_data = wide ? d : {8'h00, d[7:0]};
   endfunction

   fbpc_sync #(.W(fbpc_pkg::DATA_W)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (dq_pin),
      .q   (dq_sync)
   );

   // =========================================================
   // Next-state and pin logic
   always_comb begin
      st_nxt        = st_r;
      op_nxt        = op_r;
      second_nxt    = second_r;
      cnt_nxt       = cnt_r;
      wdata_nxt     = wdata_r;
      busy_nxt      = busy;
      rsp_valid_nxt = 1'b0;
      rsp_data_nxt  = rsp_data;
      addr_nxt      = flash_addr;
      dq_nxt        = dq_drive;
      dq_oe_n_nxt   = dq_oe_n;
      cs_n_nxt      = chip_sel_n;
      oe_n_nxt      = out_en_n;
      we_n_nxt      = write_n;
      rp_n_nxt      = reset_powerdown_n;
      wp_nxt        = protect_n;             // Lock-down control
      case (st_r)
         fbpc_pkg::FBPC_IDLE: begin
            cs_n_nxt    = 1'b1;              // Standby when idle
            oe_n_nxt    = 1'b1;
            we_n_nxt    = 1'b1;
            dq_oe_n_nxt = 1'b1;
            busy_nxt    = 1'b0;
            second_nxt  = 1'b0;
            if (req_valid) begin
               busy_nxt  = 1'b1;
               op_nxt    = req_op;
               cnt_nxt   = fbpc_pkg::SETUP_CYC;
               addr_nxt  = mask_addr(req_addr, wide_bus);
               wdata_nxt = fit_data(req_data, wide_bus);
               if (req_op == fbpc_pkg::FBPC_OP_RESET) begin
                  rp_n_nxt = 1'b0;
                  cnt_nxt  = fbpc_pkg::RST_CYC;
                  st_nxt   = fbpc_pkg::FBPC_RST;
               end else begin
                  cs_n_nxt = 1'b0;
                  if (req_op == fbpc_pkg::FBPC_OP_READ) begin
                     oe_n_nxt = 1'b0;
                  end else begin
                     dq_oe_n_nxt = 1'b0;
                     dq_nxt      = {8'h00, req_cmd}; // Command on low byte
                  end
                  st_nxt = fbpc_pkg::FBPC_SETUP;
               end
            end
         end
         fbpc_pkg::FBPC_SETUP: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               if (op_r == fbpc_pkg::FBPC_OP_READ) begin
                  cnt_nxt = fbpc_pkg::ACCESS_CYC;
               end else begin
                  cnt_nxt  = fbpc_pkg::PULSE_CYC;
                  we_n_nxt = 1'b0;           // Write strobe only off reads
               end
               st_nxt = fbpc_pkg::FBPC_PULSE;
            end
         end
         fbpc_pkg::FBPC_PULSE: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               if (op_r == fbpc_pkg::FBPC_OP_READ) begin
                  // Full word on word parts, low byte on byte parts; status on low byte only
                  rsp_data_nxt  = fit_data(dq_sync, wide_bus);
                  rsp_valid_nxt = 1'b1;
                  oe_n_nxt      = 1'b1;
               end else begin
                  we_n_nxt = 1'b1;           // Rising edge latches
               end
               cnt_nxt = fbpc_pkg::HOLD_CYC;
               st_nxt  = fbpc_pkg::FBPC_HOLD;
            end
         end
         fbpc_pkg::FBPC_HOLD: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               if (op_r == fbpc_pkg::FBPC_OP_PAIR && !second_r) begin
                  // Address kept steady; device takes it at the data strobe
                  second_nxt = 1'b1;
                  dq_nxt     = wdata_r;      // Program data, second cycle
                  cnt_nxt    = fbpc_pkg::SETUP_CYC;
                  st_nxt     = fbpc_pkg::FBPC_SETUP;
               end else begin
                  cs_n_nxt    = 1'b1;
                  dq_oe_n_nxt = 1'b1;        // Release bus, device may drive
                  busy_nxt    = 1'b0;
                  st_nxt      = fbpc_pkg::FBPC_IDLE;
               end
            end
         end
         fbpc_pkg::FBPC_RST: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               rp_n_nxt = 1'b1;              // Release: locked, read array
               busy_nxt = 1'b0;
               st_nxt   = fbpc_pkg::FBPC_IDLE;
            end
         end
         default: begin
            st_nxt = fbpc_pkg::FBPC_IDLE;
         end
      endcase
   end

   // =========================================================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r              <= fbpc_pkg::FBPC_IDLE;
         op_r              <= 2'h0;
         second_r          <= 1'b0;
         cnt_r             <= 4'h0;
         wdata_r           <= '0;
         busy              <= 1'b0;
         rsp_valid         <= 1'b0;
         rsp_data          <= '0;
         flash_addr        <= '0;
         dq_drive          <= '0;
         dq_oe_n           <= 1'b1;
         chip_sel_n        <= 1'b1;
         out_en_n          <= 1'b1;
         write_n           <= 1'b1;
         reset_powerdown_n <= 1'b1;
         write_protect_n   <= 1'b0;         // Lock-down on by default
      end else begin
         st_r              <= st_nxt;
         op_r              <= op_nxt;
         second_r          <= second_nxt;
         cnt_r             <= cnt_nxt;
         wdata_r           <= wdata_nxt;
         busy              <= busy_nxt;
         rsp_valid         <= rsp_valid_nxt;
         rsp_data          <= rsp_data_nxt;
         flash_addr        <= addr_nxt;
         dq_drive          <= dq_nxt;
         dq_oe_n           <= dq_oe_n_nxt;
         chip_sel_n        <= cs_n_nxt;
         out_en_n          <= oe_n_nxt;
         write_n           <= we_n_nxt;
         reset_powerdown_n <= rp_n_nxt;
         write_protect_n   <= wp_nxt;
      end
   end

   // =========================================================
   // Checks
   sequence s_we_rise;
      !write_n ##1 write_n;
   endsequence

   chk_read_no_write: assert property (@(posedge clk) disable iff (rst)
      !out_en_n |-> write_n && reset_powerdown_n)
      else $error("write strobe or reset low during read");
   chk_oe_needs_cs: assert property (@(posedge clk) disable iff (rst)
      !out_en_n |-> !chip_sel_n)
      else $error("output enable without chip select");
   chk_no_contention: assert property (@(posedge clk) disable iff (rst)
      !out_en_n |-> dq_oe_n)
      else $error("host drives bus during read");
   chk_write_drive: assert property (@(posedge clk) disable iff (rst)
      !write_n |-> !dq_oe_n && !chip_sel_n)
      else $error("write strobe without driven data");
   chk_addr_stable: assert property (@(posedge clk) disable iff (rst)
      s_we_rise |-> $stable(flash_addr) && $stable(dq_drive))
      else $error("address or data moved at strobe rise");
   chk_reset_quiet: assert property (@(posedge clk) disable iff (rst)
      !reset_powerdown_n |-> write_n && chip_sel_n)
      else $error("bus active during reset");
   chk_addr_width: assert property (@(posedge clk) disable iff (rst)
      (!chip_sel_n && wide_bus) |-> !flash_addr[fbpc_pkg::ADDR_W-1])
      else $error("top address bit set on word part");
   chk_rst_len: assert property (@(posedge clk) disable iff (rst)
      $fell(reset_powerdown_n) |-> !reset_powerdown_n [*4])
      else $error("reset pulse too short");
   chk_read_done: assert property (@(posedge clk) disable iff (rst)
      $fell(out_en_n) |-> ##[1:10] rsp_valid)
      else $error("read gave no response");
endmodule

// >>> fbpc_flash_model.sv
// Behavioural flash device seen by the host controller's pins.
// Assumes the bench resolves the data wire and feeds it back here.
`timescale 1ns/1ps
module fbpc_flash_model #(
   parameter logic [7:0] PROG_CMD = 8'h40   // Program command, plain default
) (
   input  wire logic        chip_sel_n,        // Chip select, low active
   input  wire logic        out_en_n,          // Output enable, low active
   input  wire logic        write_n,           // Write strobe, low active
   input  wire logic        reset_powerdown_n, // Reset pin, low active
   input  wire logic [21:0] addr,              // Address pins
   input  wire logic [15:0] dq_in,             // Resolved data wire
   output logic      [15:0] dq_drv,            // Device drive or float value
   output int               wr_count,          // Accepted strobes
   output logic      [7:0]  last_cmd,          // Last command byte
   output int               bad_rd             // Reads with strobes low
);
   // ========================================
   // State
   logic [15:0] mem [16];                      // Small array, low address bits
   logic        second;                        // Next strobe carries data
   logic [15:0] last;                          // Last driven value
   logic        dq_en;                         // Device drives data
   logic [15:0] rd;                            // Array word at address
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
      second = 1'b0;
      wr_count = 0;
      last_cmd = 8'h00;
      bad_rd = 0;
      last = 16'h0000;
   end
   // Latch on the strobe's rising edge; ignored while in reset
   always @(posedge write_n) begin
      if (!chip_sel_n && reset_powerdown_n) begin
         wr_count++;
         if (second) begin
            mem[addr[3:0]] = dq_in;
            second = 1'b0;
         end else begin
            last_cmd = dq_in[7:0];
            second = (dq_in[7:0] == PROG_CMD);
         end
      end
   end
   // Reset drops any half-entered sequence, array mode afterwards
   always @(negedge reset_powerdown_n) second = 1'b0;
   // Host must keep strobe and reset high through a read
   always @(negedge out_en_n) begin
      if (!write_n || !reset_powerdown_n) bad_rd++;
   end
   // Drive only when selected and enabled; otherwise a floating guess
   assign dq_en = !chip_sel_n && !out_en_n && reset_powerdown_n;
   assign rd = mem[addr[3:0]];
   always @(dq_en or rd) if (dq_en) last = rd;
   // Released wire shows the inverse so stale data never matches
   assign dq_drv = dq_en ? rd : ~last;
endmodule

// >>> flash_bus_pin_control_tb.sv
// Self-checking bench for the host-side flash pin controller.
// Assumes the device model above on the far side of the pins.
`timescale 1ns/1ps
module flash_bus_pin_control_tb;
   // ========================================
   // Signals
   logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, wide_bus = 1'b1;
   logic protect_n = 1'b1, busy, rsp_valid, dq_oe_n;
   logic chip_sel_n, out_en_n, write_n, reset_powerdown_n, write_protect_n;
   logic [1:0]  req_op = 2'b00;                // Request kind
   logic [21:0] req_addr = 22'h000000, addr_o; // Address
   logic [7:0]  req_cmd = 8'h00, last_cmd;     // Command byte
   logic [15:0] req_data = 16'h0000, rsp_data, dq_o, dq_drv, got;
   wire  [15:0] dq = !dq_oe_n ? dq_o : dq_drv; // Resolved data wire
   int miscompares = 0, samples_checked = 0, cyc = 0, wlo = 0, rlo = 0;
   int lat, wr_count, bad_rd, w0;
   // ========================================
   // Clock, counters and timeout
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (!write_n) wlo++;
      if (!reset_powerdown_n) rlo++;
      if (cyc == 4000) begin
         miscompares++;                        // Hang cut short
         end_of_test();
      end
   end
   fbpc_host u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_cmd(req_cmd),
      .req_data(req_data), .wide_bus(wide_bus), .protect_n(protect_n),
      .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .flash_addr(addr_o), .dq_drive(dq_o), .dq_oe_n(dq_oe_n), .dq_pin(dq),
      .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
      .reset_powerdown_n(reset_powerdown_n),
      .write_protect_n(write_protect_n));
   fbpc_flash_model u_flash (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
      .write_n(write_n), .reset_powerdown_n(reset_powerdown_n),
      .addr(addr_o), .dq_in(dq), .dq_drv(dq_drv), .wr_count(wr_count),
      .last_cmd(last_cmd), .bad_rd(bad_rd));
   // ========================================
   // Shared tasks
   task automatic chk(input logic [21:0] g, input logic [21:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One request, then wait for the sequence end with a bound
   task automatic issue(input logic [1:0] op, input logic [21:0] a,
                        input logic [7:0] c, input logic [15:0] d);
      int n;
      n = 0;
      lat = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_cmd <= c;
      req_data <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (rsp_valid === 1'b1) begin
            lat = n;
            got = rsp_data;
         end
      end while (busy !== 1'b0 && n < 40);
      chk(busy, 1'b0);                         // Sequence must end
   endtask
   // ========================================
   // Scenarios
   task automatic t_pair_read();           // Program then read back
      w0 = wr_count;
      issue(2'd2, 22'h000005, 8'h40, 16'ha5c3);
      chk(wr_count - w0, 2);
      issue(2'd0, 22'h000005, 8'h00, 16'h0000);
      chk(lat, fbpc_pkg::SETUP_CYC + fbpc_pkg::ACCESS_CYC);
      chk(got, 16'ha5c3);
   endtask
   task automatic t_cmd();                  // Single command write
      w0 = wr_count;
      wlo = 0;
      issue(2'd1, 22'h000002, 8'h70, 16'h0000);
      chk(last_cmd, 8'h70);
      chk(wlo, fbpc_pkg::PULSE_CYC);
      chk(wr_count - w0, 1);
   endtask
   task automatic t_width();                // Byte and word parts
      @(posedge clk);
      wide_bus <= 1'b0;
      issue(2'd2, 22'h3ffff9, 8'h40, 16'h5a3c);
      issue(2'd0, 22'h3ffff9, 8'h00, 16'h0000);
      chk(got, 16'h003c);
      chk(addr_o, 22'h3ffff9);
      @(posedge clk);
      wide_bus <= 1'b1;
      issue(2'd0, 22'h3ffff9, 8'h00, 16'h0000);
      chk(addr_o, 22'h1ffff9);
      chk(got, 16'h003c);
   endtask
   task automatic t_reset();                // Reset aborts a sequence
      issue(2'd1, 22'h000007, 8'h40, 16'h0000);
      rlo = 0;
      issue(2'd3, 22'h000000, 8'h00, 16'h0000);
      chk(rlo, fbpc_pkg::RST_CYC);
      issue(2'd1, 22'h000007, 8'h99, 16'h0000);
      issue(2'd0, 22'h000007, 8'h00, 16'h0000);
      chk(got, 16'h0000);
   endtask
   task automatic t_refuse();               // Request while busy dropped
      w0 = wr_count;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= 2'd0;
      req_addr <= 22'h000005;
      @(posedge clk);
      req_op <= 2'd1;
      req_cmd <= 8'h55;
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      chk(wr_count - w0, 0);
      chk(rsp_data, 16'ha5c3);
   endtask
   task automatic t_protect();              // Protect pin follows request
      @(posedge clk);
      protect_n <= 1'b0;
      @(posedge clk);
      #1;
      chk(write_protect_n, 1'b0);
      @(posedge clk);
      protect_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(write_protect_n, 1'b1);
   endtask
   // ========================================
   // Closing report and main sequence
   task automatic end_of_test();
      $display("miscompares=%0d samples_checked=%0d", miscompares,
               samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_pair_read();
      t_cmd();
      t_width();
      t_reset();
      t_refuse();
      t_protect();
      chk(bad_rd, 0);
      end_of_test();
   end
endmodule
